// ===== hw/spm_pkg.sv
// Constants, register map and carrier types of the switch power-mode control.
// Assumes a single 50 MHz system clock and an 8-bit register port.
package spm_pkg;

    localparam int unsigned SPM_NPHY = 2;

    // Register map on the 8-bit register port.
    localparam logic [7:0] SPM_ADDR_GPC = 8'h0e;
    localparam logic [7:0] SPM_ADDR_SLEEP = 8'h0f;
    localparam logic [7:0] SPM_ADDR_STATUS = 8'h10;
    localparam logic [7:0] SPM_ADDR_PCTL_BASE = 8'h1d;
    localparam logic [7:0] SPM_PCTL_STRIDE = 8'h10;

    // Field layout.
    localparam int unsigned SPM_MODE_LSB = 3;
    localparam int unsigned SPM_MODE_MSB = 4;
    localparam int unsigned SPM_PCTL_PDN_BIT = 3;

    // Reset values.
    localparam logic [7:0] SPM_GPC_RST = 8'h00;
    localparam logic [7:0] SPM_SLEEP_RST = 8'h50;
    localparam logic [7:0] SPM_PCTL_RST = 8'h00;
    localparam logic [7:0] SPM_ZERO8 = 8'h00;

    // Global power modes as coded in the mode field.
    typedef enum logic [1:0] {
        SPM_MODE_NORMAL = 2'h0,
        SPM_MODE_EDET = 2'h1,
        SPM_MODE_SOFT_PD = 2'h2,
        SPM_MODE_PSAVE = 2'h3
    } spm_mode_t;

    // Timing.
    localparam int unsigned SPM_CLK_PERIOD_NS = 20;
    localparam int unsigned SPM_LP_WIDTH_NS = 120;
    localparam int unsigned SPM_LP_PERIOD_MS = 1000;
    localparam int unsigned SPM_SLEEP_UNIT_US = 1000;
    localparam int unsigned SPM_LP_WIDTH_CYC =
        (SPM_LP_WIDTH_NS + SPM_CLK_PERIOD_NS - 1) / SPM_CLK_PERIOD_NS;
    localparam int unsigned SPM_LP_PERIOD_CYC =
        SPM_LP_PERIOD_MS * 1000000 / SPM_CLK_PERIOD_NS;
    localparam int unsigned SPM_SLEEP_UNIT_CYC =
        SPM_SLEEP_UNIT_US * 1000 / SPM_CLK_PERIOD_NS;

    // Register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spm_req_t;

    // Enables of one PHY.
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic edet_en;
    } spm_phy_en_t;

endpackage

// ===== hw/spm_power_ctrl.sv
// Power-mode controller of the switch: mode register, energy detect sleep,
// soft power-down with wake on host access, power saving and per-PHY
// power-down.
// Assumes cable energy and link inputs come from analog blocks (async), and
// the management power-down and auto-negotiation inputs share clk_sys_i.
//
// Summary of operation
// - Mode field: normal, energy detect, power-down, saving.
// - Port control bit 3 powers down PHY.
// - Mode field resets to normal.
// - Normal mode: clocks, PHYs, MACs, host on.
// - Host write in normal changes mode.
// - Low-power state emits 120 ns pulses each second.
// - Idle beyond go-sleep time enters low power.
// - Low power keeps only receiver energy detect.
// - Cable energy returns to energy detect normal.
// - Soft power-down disables clocks, PHYs, MACs.
// - Host access wakes, resets registers to default.
// - Saving needs mode 11, autoneg, no cable.
// - Saving keeps clocks, MAC, registers, host.
// - Saving keeps transmitter, turns off unused receiver.
// - Line activity restores full PHY power.
// - Host write in saving changes mode.
// - Management register bit 11 also powers down.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module spm_power_ctrl
    import spm_pkg::*;
#(
    parameter int unsigned LP_PERIOD_CYC = spm_pkg::SPM_LP_PERIOD_CYC,
    parameter int unsigned SLEEP_UNIT_CYC = spm_pkg::SPM_SLEEP_UNIT_CYC
)
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port.
    input wire spm_pkg::spm_req_t req_i,
    output logic [7:0] rdata_o,
    // Line and PHY management inputs.
    input wire logic [spm_pkg::SPM_NPHY-1:0] cable_energy_i,
    input wire logic [spm_pkg::SPM_NPHY-1:0] link_up_i,
    input wire logic [spm_pkg::SPM_NPHY-1:0] autoneg_en_i,
    input wire logic [spm_pkg::SPM_NPHY-1:0] mgmt_pdn_i,
    // Power enables.
    output logic pll_clk_en_o,
    output logic mac_en_o,
    output logic host_if_en_o,
    output spm_pkg::spm_phy_en_t [spm_pkg::SPM_NPHY-1:0] phy_en_o,
    output logic link_pulse_o,
    output logic soft_rst_o,
    output spm_pkg::spm_mode_t mode_o
);
    import spm_pkg::*;

    typedef enum logic [2:0] {
        SPM_ST_NORMAL,
        SPM_ST_ED_ACTIVE,
        SPM_ST_ED_LOW,
        SPM_ST_SOFT_PD,
        SPM_ST_PSAVE
    } spm_state_t;

    localparam logic [31:0] LP_LAST = 32'(LP_PERIOD_CYC - 1);
    localparam logic [31:0] LP_WIDTH = 32'(SPM_LP_WIDTH_CYC);
    localparam logic [31:0] UNIT_LAST = 32'(SLEEP_UNIT_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and per-PHY decode.

    logic [SPM_NPHY-1:0] energy_m_q;
    logic [SPM_NPHY-1:0] energy_q;
    logic [SPM_NPHY-1:0] link_m_q;
    logic [SPM_NPHY-1:0] link_q;
    logic [7:0] gpc_q;
    logic [7:0] sleep_q;
    logic [7:0] pctl_q [SPM_NPHY];
    logic [SPM_NPHY-1:0] pctl_hit;
    logic [SPM_NPHY-1:0] port_pdn;
    logic [SPM_NPHY-1:0] psave_port;
    spm_state_t state_q;
    spm_state_t state_d;

    always_ff @(posedge clk_sys_i)
    begin
        energy_m_q <= cable_energy_i;
        energy_q <= energy_m_q;
        link_m_q <= link_up_i;
        link_q <= link_m_q;
    end

    wire energy_any = |energy_q;
    wire any_access = req_i.wr | req_i.rd;
    // In soft power-down a host access only wakes the block: a write is
    // dropped and a read returns zero, since every register resets anyway.
    wire wake_access = (state_q == SPM_ST_SOFT_PD) && any_access;
    wire reg_rst = rst_i | wake_access;
    wire wr_ok = req_i.wr && !wake_access;
    wire gpc_hit = (req_i.addr == SPM_ADDR_GPC);
    wire sleep_hit = (req_i.addr == SPM_ADDR_SLEEP);
    wire status_hit = (req_i.addr == SPM_ADDR_STATUS);

    genvar gi;
    generate
        for (gi = 0; gi < SPM_NPHY; gi++)
        begin : g_port
            assign pctl_hit[gi] = (req_i.addr ==
                8'(SPM_ADDR_PCTL_BASE + 8'(gi) * SPM_PCTL_STRIDE));
            assign port_pdn[gi] = pctl_q[gi][SPM_PCTL_PDN_BIT]
                | mgmt_pdn_i[gi];
            // Saving applies only to an auto-negotiating port with no cable.
            assign psave_port[gi] = (state_q == SPM_ST_PSAVE)
                && autoneg_en_i[gi] && !link_q[gi] && !energy_q[gi];

            always_ff @(posedge clk_sys_i)
            begin
                if (reg_rst)
                    pctl_q[gi] <= SPM_PCTL_RST;
                else if (wr_ok && pctl_hit[gi])
                    pctl_q[gi] <= req_i.wdata;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    wire [1:0] mode_field = gpc_q[SPM_MODE_MSB:SPM_MODE_LSB];
    wire mode_wr = wr_ok && gpc_hit;

    always_ff @(posedge clk_sys_i)
    begin
        if (reg_rst)
        begin
            gpc_q <= SPM_GPC_RST;
            sleep_q <= SPM_SLEEP_RST;
        end
        else
        begin
            if (mode_wr)
                gpc_q <= req_i.wdata;
            if (wr_ok && sleep_hit)
                sleep_q <= req_i.wdata;
        end
    end

    logic [7:0] pctl_rd;
    always_comb
    begin
        pctl_rd = SPM_ZERO8;
        for (int i = 0; i < SPM_NPHY; i++)
        begin
            if (pctl_hit[i])
                pctl_rd = pctl_q[i];
        end
    end

    wire [7:0] status_val = {5'h00, 3'(state_q)};
    wire [7:0] rd_mux = gpc_hit ? gpc_q :
                        sleep_hit ? sleep_q :
                        status_hit ? status_val : pctl_rd;
    wire [7:0] rdata_d = (req_i.rd && !wake_access) ? rd_mux : SPM_ZERO8;

    ////////////////////////////////////////////////////////////////////////
    // Energy detect idle timer and link pulse generator.

    logic [31:0] unit_cnt_q;
    logic [8:0] idle_q;
    logic [31:0] lp_cnt_q;

    wire ed_timing = (state_q == SPM_ST_ED_ACTIVE);
    wire unit_tick = (unit_cnt_q == UNIT_LAST);
    wire idle_over = (idle_q > {1'b0, sleep_q});
    wire ed_low = (state_q == SPM_ST_ED_LOW);
    wire lp_d = ed_low && (lp_cnt_q < LP_WIDTH);

    // The idle count stops at its top bit, so a long quiet spell cannot
    // wrap it back below the go-sleep value.
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || !ed_timing || energy_any)
        begin
            unit_cnt_q <= '0;
            idle_q <= '0;
        end
        else
        begin
            unit_cnt_q <= unit_tick ? '0 : unit_cnt_q + 32'h1;
            if (unit_tick && !idle_q[8])
                idle_q <= idle_q + 9'h1;
        end
    end

    // The pulse counter restarts on each entry to the low-power state, so
    // the first pulse leaves at once and the rest follow once per period.
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || !ed_low)
            lp_cnt_q <= '0;
        else
            lp_cnt_q <= (lp_cnt_q == LP_LAST) ? '0 : lp_cnt_q + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state machine.
    // Leaving energy detect passes through normal for one cycle, which also
    // clears the idle and pulse timers; power saving goes straight to the new mode.

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SPM_ST_NORMAL, SPM_ST_PSAVE:
            begin
                case (spm_mode_t'(mode_field))
                    SPM_MODE_EDET: state_d = SPM_ST_ED_ACTIVE;
                    SPM_MODE_SOFT_PD: state_d = SPM_ST_SOFT_PD;
                    SPM_MODE_PSAVE: state_d = SPM_ST_PSAVE;
                    default: state_d = SPM_ST_NORMAL;
                endcase
            end
            SPM_ST_ED_ACTIVE:
            begin
                if (mode_field != SPM_MODE_EDET)
                    state_d = SPM_ST_NORMAL;
                else if (idle_over)
                    state_d = SPM_ST_ED_LOW;
            end
            SPM_ST_ED_LOW:
            begin
                if (mode_field != SPM_MODE_EDET)
                    state_d = SPM_ST_NORMAL;
                else if (energy_any)
                    state_d = SPM_ST_ED_ACTIVE;
            end
            SPM_ST_SOFT_PD:
            begin
                if (any_access)
                    state_d = SPM_ST_NORMAL;
            end
            default: state_d = SPM_ST_NORMAL;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            state_q <= SPM_ST_NORMAL;
        else
            state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output enables.
    // Every enable is registered, so it lags the state by one cycle.

    wire core_on = (state_q == SPM_ST_NORMAL) || (state_q == SPM_ST_PSAVE)
        || (state_q == SPM_ST_ED_ACTIVE);
    wire clk_on = core_on;
    spm_phy_en_t [SPM_NPHY-1:0] phy_en_d;

    always_comb
    begin
        for (int i = 0; i < SPM_NPHY; i++)
        begin
            phy_en_d[i].tx_en = core_on && !port_pdn[i];
            phy_en_d[i].rx_en = core_on && !port_pdn[i]
                && !psave_port[i];
            phy_en_d[i].edet_en = (core_on || ed_low)
                && !port_pdn[i];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pll_clk_en_o <= 1'b1;
            mac_en_o <= 1'b1;
            host_if_en_o <= 1'b1;
            phy_en_o <= '0;
            link_pulse_o <= 1'b0;
            soft_rst_o <= 1'b0;
            mode_o <= SPM_MODE_NORMAL;
            rdata_o <= SPM_ZERO8;
        end
        else
        begin
            pll_clk_en_o <= clk_on;
            mac_en_o <= core_on;
            host_if_en_o <= core_on;
            phy_en_o <= phy_en_d;
            link_pulse_o <= lp_d;
            soft_rst_o <= wake_access;
            mode_o <= spm_mode_t'(mode_field);
            rdata_o <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_reset_mode: assert property (
        $past(rst_i) |-> gpc_q == SPM_GPC_RST)
        else $error("mode register not at default after reset");
    chk_mode_write: assert property (
        state_q == SPM_ST_NORMAL && req_i.wr && gpc_hit
        |=> mode_field == $past(req_i.wdata[SPM_MODE_MSB:SPM_MODE_LSB]))
        else $error("mode write not taken in normal mode");
    chk_soft_pd_off: assert property (
        state_q == SPM_ST_SOFT_PD |=> !pll_clk_en_o && !mac_en_o
        && phy_en_o == '0)
        else $error("power-down left a block enabled");
    chk_wake_reset: assert property (
        state_q == SPM_ST_SOFT_PD && any_access
        |=> state_q == SPM_ST_NORMAL && soft_rst_o && gpc_q == SPM_GPC_RST
        && sleep_q == SPM_SLEEP_RST)
        else $error("host access did not wake and reset");
    chk_ed_sleep: assert property (
        state_q == SPM_ST_ED_ACTIVE && mode_field == SPM_MODE_EDET
        && idle_over |=> state_q == SPM_ST_ED_LOW)
        else $error("idle time elapsed without entering low power");
    chk_ed_wake: assert property (
        state_q == SPM_ST_ED_LOW && mode_field == SPM_MODE_EDET
        && energy_any |=> state_q == SPM_ST_ED_ACTIVE)
        else $error("energy did not wake low power state");
    // A pulse cut short by cable energy ends outside the low-power state.
    chk_pulse_width: assert property (
        $fell(link_pulse_o) && ed_low
        |-> $past(link_pulse_o, 1) && $past(link_pulse_o, 6)
        && !$past(link_pulse_o, 7))
        else $error("link pulse width wrong");
    chk_ed_low_off: assert property (
        state_q == SPM_ST_ED_LOW |=> !pll_clk_en_o && !mac_en_o)
        else $error("low power state left core enabled");
    chk_psave_keep: assert property (
        state_q == SPM_ST_PSAVE |=> pll_clk_en_o && mac_en_o && host_if_en_o)
        else $error("saving mode turned off core");
    chk_idle_clear: assert property (
        energy_any |=> idle_q == 9'h000)
        else $error("idle counter not cleared by energy");
    chk_normal_on: assert property (
        state_q == SPM_ST_NORMAL |=> pll_clk_en_o && mac_en_o && host_if_en_o)
        else $error("normal mode left core disabled");
    chk_soft_rst_once: assert property (soft_rst_o |=> !soft_rst_o)
        else $error("internal reset longer than one cycle");
    chk_read_idle: assert property (
        !req_i.rd |=> rdata_o == SPM_ZERO8)
        else $error("read data not zero outside a read");

    generate
        for (gi = 0; gi < SPM_NPHY; gi++)
        begin : g_chk
            chk_port_pdn: assert property (
                port_pdn[gi] |=> !phy_en_o[gi].tx_en && !phy_en_o[gi].rx_en)
                else $error("port power-down not applied");
            chk_psave_rx: assert property (
                psave_port[gi] && !port_pdn[gi]
                |=> phy_en_o[gi].tx_en && !phy_en_o[gi].rx_en)
                else $error("saving mode receiver or transmitter wrong");
            chk_ed_low_rx: assert property (
                ed_low && !port_pdn[gi] |=> !phy_en_o[gi].tx_en
                && !phy_en_o[gi].rx_en && phy_en_o[gi].edet_en)
                else $error("low power state left receiver wrong");
        end
    endgenerate

    cov_ed_sleep_wake: cover property (
        state_q == SPM_ST_ED_LOW ##[1:1000] state_q == SPM_ST_ED_ACTIVE);
    cov_soft_wake: cover property (wake_access);
    cov_psave_port: cover property (|psave_port);
    cov_link_pulse: cover property ($rose(link_pulse_o));
    cov_port_pdn: cover property (|port_pdn);

endmodule

// ===== tb/test_spm_power_ctrl.sv
// Self-checking bench of the switch power-mode controller.
// Assumes hw/spm_pkg.sv and hw/spm_power_ctrl.sv are compiled first.
`timescale 1ns/1ps
module test_spm_power_ctrl;
    import spm_pkg::*;

    localparam int LIM = 300;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    spm_req_t req = '0;
    logic [7:0] rdata;
    logic [1:0] energy = '0;
    logic [1:0] link = '0;
    logic [1:0] aneg = '0;
    logic [1:0] mpdn = '0;
    logic pll, mac, host, pulse, srst;
    spm_phy_en_t [1:0] phy;
    spm_mode_t mode;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] rd_v;

    always #10 clk_sys_i = ~clk_sys_i;

    // Short counts keep the sleep and pulse timers within a brief run.
    spm_power_ctrl #(.LP_PERIOD_CYC(40), .SLEEP_UNIT_CYC(4)) u_spm_power_ctrl (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .req_i(req),
        .rdata_o(rdata),
        .cable_energy_i(energy),
        .link_up_i(link),
        .autoneg_en_i(aneg),
        .mgmt_pdn_i(mpdn),
        .pll_clk_en_o(pll),
        .mac_en_o(mac),
        .host_if_en_o(host),
        .phy_en_o(phy),
        .link_pulse_o(pulse),
        .soft_rst_o(srst),
        .mode_o(mode)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tmo(input int k);
        if (k >= LIM)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            conclude();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        req <= '0;
        #1;
    endtask

    // Read data are taken in the one cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        req <= '0;
        #1;
        rd_v = rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(mode, SPM_MODE_NORMAL);
        chk({pll, mac, host}, 8'h07);
        chk(phy, 8'h3f);
        rd(SPM_ADDR_GPC);
        chk(rd_v, SPM_GPC_RST);
        rd(SPM_ADDR_SLEEP);
        chk(rd_v, SPM_SLEEP_RST);
        rd(SPM_ADDR_PCTL_BASE + SPM_PCTL_STRIDE);
        chk(rd_v, SPM_PCTL_RST);
        wr(8'h30, 8'hff);
        rd(8'h30);
        chk(rd_v, SPM_ZERO8);
        $display("test reset done");
    endtask

    task automatic t_port();
        wr(SPM_ADDR_PCTL_BASE, 8'h08);
        cyc(3);
        chk(phy[0], 8'h00);
        chk(phy[1], 8'h07);
        rd(SPM_ADDR_PCTL_BASE);
        chk(rd_v, 8'h08);
        @(posedge clk_sys_i);
        mpdn <= 2'b10;
        cyc(3);
        chk(phy[1], 8'h00);
        wr(SPM_ADDR_PCTL_BASE, 8'h00);
        @(posedge clk_sys_i);
        mpdn <= 2'b00;
        cyc(3);
        chk(phy, 8'h3f);
        $display("test port done");
    endtask

    task automatic t_soft();
        wr(SPM_ADDR_SLEEP, 8'h33);
        wr(SPM_ADDR_GPC, 8'h10);
        cyc(3);
        chk(mode, SPM_MODE_SOFT_PD);
        chk({pll, mac, host}, 8'h00);
        chk(phy, 8'h00);
        rd(SPM_ADDR_GPC);
        chk(srst, 1'b1);
        chk(rd_v, SPM_ZERO8);
        cyc(2);
        chk(srst, 1'b0);
        chk({pll, mac, host}, 8'h07);
        chk(mode, SPM_MODE_NORMAL);
        rd(SPM_ADDR_SLEEP);
        chk(rd_v, SPM_SLEEP_RST);
        $display("test soft power-down done");
    endtask

    task automatic t_edet();
        int i;
        int n;
        int m;
        wr(SPM_ADDR_SLEEP, 8'h02);
        wr(SPM_ADDR_GPC, 8'h08);
        cyc(3);
        chk(mode, SPM_MODE_EDET);
        chk(pll, 1'b1);
        for (i = 0; i < LIM && pll !== 1'b0; i++)
            cyc(1);
        tmo(i);
        chk(8'(i >= 8), 8'h01);
        chk({mac, host}, 8'h00);
        chk(phy, 8'h09);
        for (i = 0; i < LIM && pulse !== 1'b1; i++)
            cyc(1);
        tmo(i);
        for (n = 0; n < LIM && pulse === 1'b1; n++)
            cyc(1);
        for (m = 0; m < LIM && pulse !== 1'b1; m++)
            cyc(1);
        tmo(n);
        tmo(m);
        chk(8'(n), 8'h06);
        chk(8'(n + m), 8'h28);
        rd(SPM_ADDR_STATUS);
        chk(rd_v, 8'h02);
        @(posedge clk_sys_i);
        energy <= 2'b01;
        for (i = 0; i < LIM && pll !== 1'b1; i++)
            cyc(1);
        tmo(i);
        chk(mode, SPM_MODE_EDET);
        chk(phy[0], 8'h07);
        wr(SPM_ADDR_GPC, 8'h00);
        @(posedge clk_sys_i);
        energy <= 2'b00;
        cyc(3);
        chk(mode, SPM_MODE_NORMAL);
        $display("test energy detect done");
    endtask

    task automatic t_psave();
        int i;
        @(posedge clk_sys_i);
        aneg <= 2'b01;
        wr(SPM_ADDR_GPC, 8'h18);
        cyc(3);
        chk(mode, SPM_MODE_PSAVE);
        chk({pll, mac, host}, 8'h07);
        chk(phy[0].tx_en, 1'b1);
        chk(phy[0].rx_en, 1'b0);
        chk(phy[1], 8'h07);
        rd(SPM_ADDR_SLEEP);
        chk(rd_v, 8'h02);
        rd(SPM_ADDR_STATUS);
        chk(rd_v, 8'h04);
        @(posedge clk_sys_i);
        link <= 2'b01;
        for (i = 0; i < LIM && phy[0].rx_en !== 1'b1; i++)
            cyc(1);
        tmo(i);
        chk(phy[0], 8'h07);
        wr(SPM_ADDR_GPC, 8'h00);
        cyc(3);
        chk(mode, SPM_MODE_NORMAL);
        chk(phy, 8'h3f);
        $display("test power saving done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        cyc(2);
        t_reset();
        t_port();
        t_soft();
        t_edet();
        t_psave();
        conclude();
    end
endmodule
